/* File: cmqc_map.svh */
`ifndef CMQC_MAP_SVH
`define CMQC_MAP_SVH

// ***************************************************************
// timing figures
// ***************************************************************
// system clock period
`define CMQC_CLK_PERIOD_NS 10
// longest wait for an oscillator edge before a monitor fail
`define CMQC_MON_TIMEOUT_NS 1000
// check window length in vco clock edges
`define CMQC_CHECK_WINDOW 50000
// oscillator edges that make the oscillator good
`define CMQC_OSC_OK_EDGES 4096
// clock source change: oscillator edges, then pll edges
`define CMQC_SW_OSC_EDGES 4
`define CMQC_SW_PLL_EDGES 4

// ***************************************************************
// counter widths
// ***************************************************************
`define CMQC_MON_W 8
`define CMQC_WIN_W 16
`define CMQC_OSC_W 13
`define CMQC_SW_W 3

`endif

/* File: cmqc_pkg.sv */
`default_nettype none
`include "cmqc_map.svh"

package cmqc_pkg;

  // ***************************************************************
  // state types
  // ***************************************************************
  typedef enum logic [0:0] {CMQC_CHK_IDLE, CMQC_CHK_RUN} cmqc_chk_e;

  typedef enum logic [1:0] {CMQC_SW_IDLE, CMQC_SW_OSC, CMQC_SW_PLL}
    cmqc_sw_e;

  typedef struct packed {
    logic [`CMQC_MON_W-1:0] mon_cnt;
    logic fail;
    logic sys_rst;
    logic self_clk;
    cmqc_chk_e chk;
    logic [`CMQC_WIN_W-1:0] win_cnt;
    logic [`CMQC_OSC_W-1:0] osc_cnt;
    logic osc_ok;
    cmqc_sw_e sw;
    logic [`CMQC_SW_W-1:0] sw_cnt;
    logic sw_done;
  } cmqc_state_s;

  typedef struct packed {
    logic prev;
    logic rise;
  } cmqc_edge_s;

endpackage

`default_nettype wire

/* File: cmqc_edge_det.sv */
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// rising edge detector for a sampled clock level
// ***************************************************************
module cmqc_edge_det
  import cmqc_pkg::*;
(
  input wire logic clock,  // system clock
  input wire logic nrst,   // async reset, active low
  input wire logic level,  // sampled clock level
  output logic rise        // one-cycle pulse per rising edge
);

  cmqc_edge_s q;
  cmqc_edge_s next_q;

  always_comb begin
    next_q.prev = level;
    next_q.rise = level & ~q.prev;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rise = q.rise;

endmodule

`default_nettype wire

/* File: cmqc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cmqc_map.svh"

module cmqc_top
  import cmqc_pkg::*;
#(
  parameter int CHECK_WINDOW = `CMQC_CHECK_WINDOW,
  parameter int OSC_OK_EDGES = `CMQC_OSC_OK_EDGES
) (
  input wire logic CLOCK,                  // system clock, 100 MHz
  input wire logic NRST,                   // async reset, active low
  input wire logic OSCILLATOR_CLOCK,       // sampled oscillator clock
  input wire logic PLL_CLOCK,              // sampled vco clock at min freq
  input wire logic MONITOR_ENABLE,         // supervision on
  input wire logic SELF_CLOCK_MODE_ENABLE, // fail enters self-clock mode
  input wire logic LOW_VOLTAGE_RESET,      // low-voltage reset event
  input wire logic STOP_WAKEUP,            // wake-up from full stop
  input wire logic SRC_SWITCH_REQ,         // request clock source change
  output logic MONITOR_FAIL,               // pulse: monitor fail event
  output logic SYSTEM_RESET,               // pulse: reset on fail, self-clock mode off
  output logic SELF_CLOCK_MODE,            // level: running on self clock
  output logic CHECK_ACTIVE,               // level: quality check running
  output logic OSC_OK,                     // level: oscillator judged good
  output logic CLOCK_FREEZE,               // level: clocks frozen
  output logic CPU_HALT,                   // level: processor halted
  output logic SRC_SWITCH_DONE             // pulse: source change finished
);

  // ***************************************************************
  // constants
  // ***************************************************************
  localparam int MON_CYC_I = `CMQC_MON_TIMEOUT_NS / `CMQC_CLK_PERIOD_NS;
  localparam int MON_CYC = (MON_CYC_I < 1) ? 1 : MON_CYC_I;
  localparam logic [`CMQC_MON_W-1:0] MON_LAST =
    `CMQC_MON_W'(MON_CYC - 1);
  localparam logic [`CMQC_WIN_W-1:0] WIN_LAST =
    `CMQC_WIN_W'(CHECK_WINDOW - 1);
  localparam logic [`CMQC_OSC_W-1:0] OSC_LAST =
    `CMQC_OSC_W'(OSC_OK_EDGES - 1);
  localparam logic [`CMQC_SW_W-1:0] SW_OSC_LAST =
    `CMQC_SW_W'(`CMQC_SW_OSC_EDGES - 1);
  localparam logic [`CMQC_SW_W-1:0] SW_PLL_LAST =
    `CMQC_SW_W'(`CMQC_SW_PLL_EDGES - 1);

  // ***************************************************************
  // edge detection
  // ***************************************************************
  logic osc_rise;
  logic vco_rise;

  cmqc_edge_det u_osc_edge (
    .clock(CLOCK),
    .nrst(NRST),
    .level(OSCILLATOR_CLOCK),
    .rise(osc_rise)
  );

  cmqc_edge_det u_vco_edge (
    .clock(CLOCK),
    .nrst(NRST),
    .level(PLL_CLOCK),
    .rise(vco_rise)
  );

  // ***************************************************************
  // state
  // ***************************************************************
  cmqc_state_s q;
  cmqc_state_s next_q;
  logic timeout;
  logic trigger;

  always_comb begin
    next_q = q;
    next_q.fail = 1'b0;
    next_q.sys_rst = 1'b0;
    next_q.sw_done = 1'b0;
    // clock monitor
    timeout = MONITOR_ENABLE && !osc_rise && (q.mon_cnt == MON_LAST);
    if (!MONITOR_ENABLE || osc_rise || timeout) begin
      next_q.mon_cnt = '0;
    end else begin
      next_q.mon_cnt = q.mon_cnt + 1'b1;
    end
    if (timeout) begin
      next_q.fail = 1'b1;
      if (SELF_CLOCK_MODE_ENABLE) begin
        next_q.self_clk = 1'b1;
      end else begin
        next_q.sys_rst = 1'b1;
      end
    end
    // clock quality checker
    trigger = LOW_VOLTAGE_RESET || STOP_WAKEUP || timeout;
    if (trigger) begin
      next_q.chk = CMQC_CHK_RUN;
      next_q.win_cnt = '0;
      next_q.osc_cnt = '0;
      next_q.osc_ok = 1'b0;
    end else if (q.chk == CMQC_CHK_RUN) begin
      if (osc_rise && q.osc_cnt == OSC_LAST) begin
        next_q.chk = CMQC_CHK_IDLE;
        next_q.osc_ok = 1'b1;
        next_q.self_clk = 1'b0;
      end else begin
        if (osc_rise) begin
          next_q.osc_cnt = q.osc_cnt + 1'b1;
        end
        if (vco_rise) begin
          if (q.win_cnt == WIN_LAST) begin
            next_q.win_cnt = '0;
            next_q.osc_cnt = '0;
          end else begin
            next_q.win_cnt = q.win_cnt + 1'b1;
          end
        end
      end
    end
    // clock source change freeze
    unique case (q.sw)
      CMQC_SW_IDLE: begin
        if (SRC_SWITCH_REQ) begin
          next_q.sw = CMQC_SW_OSC;
          next_q.sw_cnt = '0;
        end
      end
      CMQC_SW_OSC: begin
        if (osc_rise) begin
          if (q.sw_cnt == SW_OSC_LAST) begin
            next_q.sw = CMQC_SW_PLL;
            next_q.sw_cnt = '0;
          end else begin
            next_q.sw_cnt = q.sw_cnt + 1'b1;
          end
        end
      end
      CMQC_SW_PLL: begin
        if (vco_rise) begin
          if (q.sw_cnt == SW_PLL_LAST) begin
            next_q.sw = CMQC_SW_IDLE;
            next_q.sw_done = 1'b1;
          end else begin
            next_q.sw_cnt = q.sw_cnt + 1'b1;
          end
        end
      end
      default: begin
        next_q.sw = CMQC_SW_IDLE;
      end
    endcase
  end

  // power-on reset itself starts the first check window
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      q <= '{chk: CMQC_CHK_RUN, sw: CMQC_SW_IDLE, default: '0};
    end else begin
      q <= next_q;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign MONITOR_FAIL = q.fail;
  assign SYSTEM_RESET = q.sys_rst;
  assign SELF_CLOCK_MODE = q.self_clk;
  assign CHECK_ACTIVE = (q.chk == CMQC_CHK_RUN);
  assign OSC_OK = q.osc_ok;
  assign CLOCK_FREEZE = (q.sw != CMQC_SW_IDLE);
  assign CPU_HALT = (q.sw != CMQC_SW_IDLE);
  assign SRC_SWITCH_DONE = q.sw_done;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence s_starved;
    MONITOR_ENABLE && !osc_rise && q.mon_cnt == MON_LAST;
  endsequence

  sequence s_good_edge;
    q.chk == CMQC_CHK_RUN && !trigger && osc_rise && q.osc_cnt == OSC_LAST;
  endsequence

  sequence s_osc_done;
    q.sw == CMQC_SW_OSC && osc_rise && q.sw_cnt == SW_OSC_LAST;
  endsequence

  sequence s_pll_done;
    q.sw == CMQC_SW_PLL && vco_rise && q.sw_cnt == SW_PLL_LAST;
  endsequence

  a_fail_on_timeout: assert property (
    s_starved |=> MONITOR_FAIL ##1 !MONITOR_FAIL)
    else $error("monitor fail not raised after timeout");

  a_no_fail_disabled: assert property (
    (!MONITOR_ENABLE || osc_rise) |=> !MONITOR_FAIL && q.mon_cnt == 0)
    else $error("failure reported while disabled or clocked");

  a_fail_self_clock: assert property (
    s_starved and SELF_CLOCK_MODE_ENABLE |=>
      SELF_CLOCK_MODE && !SYSTEM_RESET)
    else $error("fail did not enter self-clock mode");

  a_fail_sys_reset: assert property (
    s_starved and !SELF_CLOCK_MODE_ENABLE |=>
      SYSTEM_RESET && MONITOR_FAIL)
    else $error("fail did not pulse system reset");

  a_check_trigger: assert property (
    (LOW_VOLTAGE_RESET || STOP_WAKEUP || timeout) |=>
      CHECK_ACTIVE && !OSC_OK && q.win_cnt == 0)
    else $error("check not started by trigger event");

  a_good_ends_window: assert property (
    s_good_edge |=> OSC_OK && !CHECK_ACTIVE && !SELF_CLOCK_MODE)
    else $error("good count did not end the window");

  a_ok_needs_count: assert property (
    $rose(OSC_OK) |-> $past(q.osc_cnt) == OSC_LAST && $past(osc_rise))
    else $error("oscillator judged good early");

  a_window_restart: assert property (
    (q.chk == CMQC_CHK_RUN && !trigger && !osc_rise && vco_rise &&
      q.win_cnt == WIN_LAST) |=>
      CHECK_ACTIVE && q.win_cnt == 0 && q.osc_cnt == 0)
    else $error("expired window did not restart");

  a_window_count: assert property (
    (q.chk == CMQC_CHK_RUN && !trigger && !osc_rise && !vco_rise) |=>
      $stable(q.win_cnt))
    else $error("window advanced without a vco edge");

  a_freeze_phases: assert property (
    s_osc_done |=> q.sw == CMQC_SW_PLL && q.sw_cnt == 0 && CLOCK_FREEZE)
    else $error("oscillator phase of freeze wrong");

  a_freeze_release: assert property (
    s_pll_done |=> SRC_SWITCH_DONE && !CLOCK_FREEZE && !CPU_HALT)
    else $error("freeze not released after pll phase");

endmodule

`default_nettype wire

/* File: cmqc_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// crystal and vco stand-in, stepped on falling system clock edges
// ***************************************************************
module cmqc_osc_model (
  input wire logic clock,          // system clock
  input wire logic osc_run,        // oscillator running
  input wire logic [7:0] osc_half, // oscillator half period, cycles
  input wire logic [7:0] pll_half, // vco half period, cycles
  output logic osc_level,          // oscillator clock level
  output logic pll_level           // vco clock level
);
  logic [7:0] oc = 8'h00;
  logic [7:0] pc = 8'h00;

  initial begin
    osc_level = 1'b0;
    pll_level = 1'b0;
  end

  always @(negedge clock) begin
    oc <= (!osc_run || oc + 8'h01 >= osc_half) ? 8'h00 : oc + 8'h01;
    if (!osc_run) begin
      osc_level <= 1'b0; // a stopped crystal rests low
    end else if (oc + 8'h01 >= osc_half) begin
      osc_level <= ~osc_level;
    end
    pc <= (pc + 8'h01 >= pll_half) ? 8'h00 : pc + 8'h01;
    if (pc + 8'h01 >= pll_half) begin
      pll_level <= ~pll_level;
    end
  end
endmodule

`default_nettype wire

/* File: cmqc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// self-checking bench, window 20 vco edges, good at 8 osc edges
// ***************************************************************
module cmqc_top_tb_top;
  localparam int GOOD = 8;
  logic clk, nrst, mon_en, scm_en, low_voltage_reset, wake, sw_req, osc_run;
  logic [7:0] osc_half, pll_half;
  logic osc, pll, osc_q, pll_q;
  logic fail, sys_rst, scm, chk_act, osc_ok, freeze, halt, sw_done;
  int errors = 0;
  int n_checks = 0;
  int osc_rises = 0;
  int pll_rises = 0;
  int fails = 0;
  int n, r0, p0;

  cmqc_osc_model i_osc (.clock(clk), .osc_run(osc_run),
    .osc_half(osc_half), .pll_half(pll_half), .osc_level(osc),
    .pll_level(pll));

  cmqc_top #(.CHECK_WINDOW(20), .OSC_OK_EDGES(GOOD)) i_dut (
    .CLOCK(clk), .NRST(nrst), .OSCILLATOR_CLOCK(osc), .PLL_CLOCK(pll),
    .MONITOR_ENABLE(mon_en), .SELF_CLOCK_MODE_ENABLE(scm_en),
    .LOW_VOLTAGE_RESET(low_voltage_reset), .STOP_WAKEUP(wake), .SRC_SWITCH_REQ(sw_req),
    .MONITOR_FAIL(fail), .SYSTEM_RESET(sys_rst), .SELF_CLOCK_MODE(scm),
    .CHECK_ACTIVE(chk_act), .OSC_OK(osc_ok), .CLOCK_FREEZE(freeze),
    .CPU_HALT(halt), .SRC_SWITCH_DONE(sw_done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    osc_q <= osc;
    pll_q <= pll;
    if (osc && !osc_q) osc_rises++;
    if (pll && !pll_q) pll_rises++;
    if (fail === 1'b1) fails++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // waits at falling edges until sig is high or lim cycles pass
  task automatic wait_hi(ref logic sig, input int lim, output int k);
    k = 0;
    while (sig !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic t_power_on();
    chk({15'h0000, chk_act}, 16'h0001);
    chk(16'({fail, sys_rst, scm, osc_ok}), 16'h0000);
    chk(16'({freeze, halt, sw_done}), 16'h0000);
    nrst = 1'b1;
    wait_hi(osc_ok, 200, n);
    chk({15'h0000, chk_act}, 16'h0000);
    chk({15'h0000, n < 100}, 16'h0001);
  endtask

  task automatic t_edge_count();
    r0 = osc_rises;
    pulse(low_voltage_reset);
    @(negedge clk);
    chk({14'h0000, osc_ok, chk_act}, 16'h0001);
    wait_hi(osc_ok, 200, n);
    chk(16'(osc_rises - r0), 16'(GOOD));
  endtask

  task automatic t_window();
    pll_half = 8'h01;
    pulse(wake);
    @(negedge clk);
    chk({14'h0000, osc_ok, chk_act}, 16'h0001);
    wait_hi(osc_ok, 400, n);
    chk({14'h0000, osc_ok, chk_act}, 16'h0001);
    osc_half = 8'h02;
    wait_hi(osc_ok, 200, n);
    chk({15'h0000, osc_ok}, 16'h0001);
  endtask

  task automatic t_quiet();
    r0 = fails;
    repeat (300) @(negedge clk);
    mon_en = 1'b0;
    osc_run = 1'b0;
    repeat (300) @(negedge clk);
    chk(16'(fails - r0), 16'h0000);
  endtask

  task automatic t_fail(input logic self_clock_mode_enable);
    osc_run = 1'b0;
    mon_en = 1'b0;
    @(negedge clk);
    scm_en = self_clock_mode_enable;
    mon_en = 1'b1;
    wait_hi(fail, 150, n);
    chk({15'h0000, n >= 100 && n <= 102}, 16'h0001);
    chk(16'({sys_rst, scm, chk_act}), 16'({!self_clock_mode_enable, self_clock_mode_enable, 1'b1}));
    @(negedge clk);
    chk({15'h0000, fail}, 16'h0000);
    osc_run = 1'b1;
    wait_hi(osc_ok, 200, n);
    chk({14'h0000, osc_ok, scm}, 16'h0002);
  endtask

  task automatic t_switch();
    osc_half = 8'h03;
    pll_half = 8'h05;
    pulse(sw_req);
    r0 = osc_rises;
    p0 = pll_rises;
    chk({14'h0000, freeze, halt}, 16'h0003);
    repeat (3) @(negedge clk);
    pulse(sw_req);
    wait_hi(sw_done, 100, n);
    chk({14'h0000, freeze, halt}, 16'h0000);
    chk({15'h0000, n <= 68}, 16'h0001);
    chk({14'h0000, osc_rises - r0 >= 4, pll_rises - p0 >= 4}, 16'h0003);
    @(negedge clk);
    chk({14'h0000, freeze, sw_done}, 16'h0000);
  endtask

  initial begin
    {nrst, mon_en, scm_en, low_voltage_reset, wake, sw_req} = 6'h10;
    osc_run = 1'b1;
    osc_half = 8'h03;
    pll_half = 8'h08;
    repeat (2) @(negedge clk);
    t_power_on();
    t_edge_count();
    t_window();
    t_quiet();
    t_fail(1'b0);
    t_fail(1'b1);
    t_switch();
    conclude();
  end

  initial begin
    #100000;
    errors++;
    conclude();
  end
endmodule

`default_nettype wire
